// File: hdl/vdsc_top.sv
// Device state machine and control loop selection with a Wishbone slave
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vdsc_consts.svh"

module vdsc_top #(
  parameter logic [3:0] CAPABILITY = `VDSC_CAP_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Connector and monitor
  input  wire logic        hw_enable_i,
  input  wire logic        ctrl_fault_i,
  input  wire vdsc_pkg::vdsc_sp_t local_sp_i,
  // Valve control outputs
  output vdsc_pkg::vdsc_state_t state_o,
  output logic             valve_func_on_o,
  output logic             driver_on_o,
  output logic             pos_loop_o,
  output logic             prs_loop_o,
  output logic             open_loop_o,
  output logic             ramp_freeze_o,
  output logic             prs_permit_o,
  output vdsc_pkg::vdsc_sp_t demand_o
);

  // ********************************************************
  // Bus slave
  // ********************************************************
  logic                  ack_r;
  logic                  req_go;
  logic                  wr_go;
  logic [31:0]           rd_nxt;
  vdsc_pkg::vdsc_cmd_t   cmd_std_r;
  vdsc_pkg::vdsc_cmd_t   cmd_vnd_r;
  vdsc_pkg::vdsc_cmd_t   cmd_std_nxt;
  vdsc_pkg::vdsc_cmd_t   cmd_vnd_nxt;
  vdsc_pkg::vdsc_cmd_t   sel_cmd;
  vdsc_pkg::vdsc_cfg_t   cfg_r;
  vdsc_pkg::vdsc_sp_t    bus_sp_r;
  vdsc_pkg::vdsc_sp_t    hold_sp_r;
  vdsc_pkg::vdsc_state_t state_r;
  vdsc_pkg::vdsc_state_t state_nxt;
  logic                  wr_std;
  logic                  wr_vnd;
  logic                  wr_cfg;
  logic                  clr_go;
  logic                  en_s1_r;
  logic                  en_s2_r;
  logic                  en_s3_r;
  logic                  en_ok_r;

  assign req_go = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_go  = req_go & wb_we_i;
  assign wr_std = wr_go & wb_sel_i[0] & (wb_adr_i == `VDSC_ADR_CMD_STD);
  assign wr_vnd = wr_go & wb_sel_i[0] & (wb_adr_i == `VDSC_ADR_CMD_VND);
  assign wr_cfg = wr_go & wb_sel_i[0] & (wb_adr_i == `VDSC_ADR_CONFIG);

  // Ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req_go;
    end
  end

  assign wb_ack_o = ack_r;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      `VDSC_ADR_CMD_STD: rd_nxt[4:0] = cmd_std_r;
      `VDSC_ADR_CMD_VND: rd_nxt[4:0] = cmd_vnd_r;
      `VDSC_ADR_CONFIG:  rd_nxt[4:0] = cfg_r;
      `VDSC_ADR_STATUS:  rd_nxt[8:0] = {driver_on_o, valve_func_on_o,
                                        en_ok_r, prs_permit_o,
                                        ramp_freeze_o,
                                        state_r == vdsc_pkg::VDSC_FAULT,
                                        state_r};
      `VDSC_ADR_CAPAB:   rd_nxt[3:0] = CAPABILITY;
      `VDSC_ADR_BUS_SP:  rd_nxt = bus_sp_r;
      `VDSC_ADR_HOLD_SP: rd_nxt = hold_sp_r;
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req_go && !wb_we_i) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ********************************************************
  // Command words and configuration
  // ********************************************************
  always_comb begin
    cmd_std_nxt = cmd_std_r;
    cmd_vnd_nxt = cmd_vnd_r;
    if (wr_std) begin
      cmd_std_nxt = wb_dat_i[4:0];
      cmd_std_nxt.fault_clr = 1'b0;
    end
    if (wr_vnd) begin
      cmd_vnd_nxt = wb_dat_i[4:0];
      cmd_vnd_nxt.fault_clr = 1'b0;
    end
  end

  // Selected word, taken from the value being written this cycle
  assign sel_cmd = cfg_r.cmd_src_vendor ? cmd_vnd_nxt : cmd_std_nxt;
  assign clr_go  = wb_dat_i[`VDSC_CMD_FCLR_BIT] &
                   ((wr_std & ~cfg_r.cmd_src_vendor) |
                    (wr_vnd &  cfg_r.cmd_src_vendor));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_std_r <= `VDSC_CMD_STD_RST;
      cmd_vnd_r <= `VDSC_CMD_VND_RST;
    end else begin
      cmd_std_r <= cmd_std_nxt;
      cmd_vnd_r <= cmd_vnd_nxt;
    end
  end

  // Loop choice not offered by this variant is ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `VDSC_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r.cmd_src_vendor <= wb_dat_i[4];
      cfg_r.sp_local       <= wb_dat_i[3];
      cfg_r.open_loop      <= wb_dat_i[2];
      if (wb_dat_i[1:0] != 2'h3 && CAPABILITY[wb_dat_i[1:0]]) begin
        cfg_r.control_loop_select <= wb_dat_i[1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_sp_r  <= 32'h0000_0000;
      hold_sp_r <= 32'h0000_0000;
    end else if (wr_go) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && wb_adr_i == `VDSC_ADR_BUS_SP) begin
          bus_sp_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
        if (wb_sel_i[b] && wb_adr_i == `VDSC_ADR_HOLD_SP) begin
          hold_sp_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // ********************************************************
  // Hardware enable synchroniser
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      en_s3_r <= 1'b0;
      en_ok_r <= 1'b0;
    end else begin
      en_s1_r <= hw_enable_i;
      en_s2_r <= en_s1_r;
      en_s3_r <= en_s2_r;
      if (en_s2_r == en_s3_r) begin
        en_ok_r <= en_s3_r;
      end
    end
  end

  // ********************************************************
  // Device state machine
  // ********************************************************
  always_comb begin
    state_nxt = state_r;
    if (ctrl_fault_i) begin
      state_nxt = vdsc_pkg::VDSC_FAULT;
    end else if (state_r == vdsc_pkg::VDSC_FAULT) begin
      if (clr_go) begin
        if (en_ok_r && sel_cmd.req[1]) begin
          state_nxt = vdsc_pkg::VDSC_HOLD;
        end else begin
          state_nxt = vdsc_pkg::VDSC_DRVOFF;
        end
      end
    end else begin
      unique case (sel_cmd.req)
        `VDSC_REQ_INIT:   state_nxt = vdsc_pkg::VDSC_INIT;
        `VDSC_REQ_DRVOFF: state_nxt = vdsc_pkg::VDSC_DRVOFF;
        `VDSC_REQ_HOLD:   state_nxt = en_ok_r ? vdsc_pkg::VDSC_HOLD
                                              : vdsc_pkg::VDSC_DRVOFF;
        `VDSC_REQ_ACTIVE: state_nxt = en_ok_r ? vdsc_pkg::VDSC_ACTIVE
                                              : vdsc_pkg::VDSC_DRVOFF;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= vdsc_pkg::VDSC_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state_o = state_r;

  // ********************************************************
  // Valve control outputs
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valve_func_on_o <= 1'b0;
      driver_on_o     <= 1'b0;
    end else begin
      valve_func_on_o <= state_nxt != vdsc_pkg::VDSC_INIT;
      driver_on_o     <= state_nxt == vdsc_pkg::VDSC_HOLD ||
                         state_nxt == vdsc_pkg::VDSC_ACTIVE;
    end
  end

  // Flags follow the selected word without touching the state; pressure permit passes only with the combined loop selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_freeze_o <= 1'b0;
      prs_permit_o  <= 1'b0;
    end else begin
      ramp_freeze_o <= sel_cmd.ramp_freeze;
      prs_permit_o  <= sel_cmd.prs_permit &&
                       cfg_r.control_loop_select == `VDSC_LOOP_PQ;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_loop_o  <= 1'b0;
      prs_loop_o  <= 1'b0;
      open_loop_o <= 1'b0;
    end else begin
      pos_loop_o  <= cfg_r.control_loop_select != `VDSC_LOOP_PRESS;
      prs_loop_o  <= cfg_r.control_loop_select == `VDSC_LOOP_PRESS ||
                     (cfg_r.control_loop_select == `VDSC_LOOP_PQ &&
                      sel_cmd.prs_permit);
      open_loop_o <= cfg_r.open_loop &&
                     cfg_r.control_loop_select != `VDSC_LOOP_PQ;
    end
  end

  // Demand routing by state and setpoint source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      demand_o <= 32'h0000_0000;
    end else begin
      unique case (state_nxt)
        vdsc_pkg::VDSC_HOLD:   demand_o <= hold_sp_r;
        vdsc_pkg::VDSC_ACTIVE: demand_o <= cfg_r.sp_local ? local_sp_i
                                                          : bus_sp_r;
        default:               demand_o <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_power_up_words: assert property ($fell(rst_i) |->
    cmd_std_r.req == `VDSC_REQ_INIT && cmd_vnd_r.req == `VDSC_REQ_ACTIVE &&
    cmd_std_r == `VDSC_CMD_STD_RST && cmd_vnd_r == `VDSC_CMD_VND_RST)
    else $error("command words not at power-up values");
  chk_enable_gate: assert property (
    (state_r == vdsc_pkg::VDSC_HOLD || state_r == vdsc_pkg::VDSC_ACTIVE)
    && $changed(state_r) |-> $past(en_ok_r))
    else $error("hold or active entered without enable");
  chk_init_valve_off: assert property (
    state_r == vdsc_pkg::VDSC_INIT |-> !valve_func_on_o)
    else $error("valve function on in init");
  chk_driver_off_state: assert property (
    state_r == vdsc_pkg::VDSC_DRVOFF |-> !driver_on_o)
    else $error("driver on in driver-off state");
  chk_fault_entry: assert property (
    ctrl_fault_i |=> state_r == vdsc_pkg::VDSC_FAULT ##1
    (state_r == vdsc_pkg::VDSC_FAULT || $past(clr_go)))
    else $error("fault not entered or left without clear");
  chk_fault_exit: assert property (
    state_r == vdsc_pkg::VDSC_FAULT && clr_go && !ctrl_fault_i |=>
    state_r == vdsc_pkg::VDSC_DRVOFF || state_r == vdsc_pkg::VDSC_HOLD)
    else $error("fault clear went to wrong state");
  chk_std_ignored: assert property (
    wr_std && cfg_r.cmd_src_vendor && !wr_vnd && !ctrl_fault_i &&
    state_r == vdsc_pkg::VDSC_ACTIVE && en_ok_r && $stable(cfg_r) |=>
    state_r == vdsc_pkg::VDSC_ACTIVE)
    else $error("standard word moved state while vendor selected");
  chk_ramp_freeze_out: assert property (
    1'b1 |=> ramp_freeze_o == $past(sel_cmd.ramp_freeze))
    else $error("ramp freeze not applied");
  chk_hold_demand: assert property (
    state_nxt == vdsc_pkg::VDSC_HOLD |=> demand_o == $past(hold_sp_r))
    else $error("hold demand not hold setpoint");
  chk_active_demand: assert property (
    state_nxt == vdsc_pkg::VDSC_ACTIVE && !cfg_r.sp_local |=>
    demand_o == $past(bus_sp_r))
    else $error("active demand not bus setpoint");
  chk_vnd_ignored: assert property (
    wr_vnd && !cfg_r.cmd_src_vendor && !wr_std && !ctrl_fault_i &&
    state_r == vdsc_pkg::VDSC_INIT && $stable(cfg_r) |=>
    state_r == vdsc_pkg::VDSC_INIT)
    else $error("vendor word moved state while standard selected");
  chk_prs_permit_gate: assert property (
    prs_permit_o |-> $past(cfg_r.control_loop_select) == `VDSC_LOOP_PQ)
    else $error("pressure permit outside combined mode");
  chk_open_loop_mode: assert property (
    open_loop_o |-> $past(cfg_r.control_loop_select) != `VDSC_LOOP_PQ)
    else $error("open loop in combined mode");
  chk_driver_on_states: assert property (
    driver_on_o |-> state_r == vdsc_pkg::VDSC_HOLD ||
    state_r == vdsc_pkg::VDSC_ACTIVE)
    else $error("driver on outside hold or active");

  cov_reach_active: cover property (
    state_r == vdsc_pkg::VDSC_DRVOFF ##[1:20] state_r == vdsc_pkg::VDSC_ACTIVE);
  cov_fault_cleared: cover property (
    state_r == vdsc_pkg::VDSC_FAULT ##1 state_r == vdsc_pkg::VDSC_HOLD);
  cov_vendor_drive: cover property (
    cfg_r.cmd_src_vendor && state_r == vdsc_pkg::VDSC_ACTIVE);
  cov_fault_to_off: cover property (
    state_r == vdsc_pkg::VDSC_FAULT ##1 state_r == vdsc_pkg::VDSC_DRVOFF);
  cov_local_demand: cover property (
    cfg_r.sp_local && state_r == vdsc_pkg::VDSC_ACTIVE);

endmodule : vdsc_top

`default_nettype wire

// File: hdl/vdsc_consts.svh
// Offsets, field positions, reset values and fixed figures of the state control
`ifndef VDSC_CONSTS_SVH
`define VDSC_CONSTS_SVH

// Register byte offsets
`define VDSC_ADR_CMD_STD  8'h00
`define VDSC_ADR_CMD_VND  8'h04
`define VDSC_ADR_CONFIG   8'h08
`define VDSC_ADR_STATUS   8'h0C
`define VDSC_ADR_CAPAB    8'h10
`define VDSC_ADR_BUS_SP   8'h14
`define VDSC_ADR_HOLD_SP  8'h18

// State request codes
`define VDSC_REQ_INIT     2'h0
`define VDSC_REQ_DRVOFF   2'h1
`define VDSC_REQ_HOLD     2'h2
`define VDSC_REQ_ACTIVE   2'h3

// Control loop codes
`define VDSC_LOOP_SPOOL   2'h0
`define VDSC_LOOP_PRESS   2'h1
`define VDSC_LOOP_PQ      2'h2

// Command word fields
`define VDSC_CMD_FCLR_BIT 2
`define VDSC_CMD_W        5

// Reset values
`define VDSC_CMD_STD_RST  5'h00
`define VDSC_CMD_VND_RST  5'h03
`define VDSC_CFG_RST      5'h00
`define VDSC_CAP_DEFAULT  4'hF

`endif

// File: hdl/vdsc_pkg.sv
// Types of the valve device state control
package vdsc_pkg;

  typedef enum logic [2:0] {
    VDSC_INIT,
    VDSC_DRVOFF,
    VDSC_HOLD,
    VDSC_ACTIVE,
    VDSC_FAULT
  } vdsc_state_t;

  typedef struct packed {
    logic       prs_permit;
    logic       ramp_freeze;
    logic       fault_clr;
    logic [1:0] req;
  } vdsc_cmd_t;

  typedef struct packed {
    logic       cmd_src_vendor;
    logic       sp_local;
    logic       open_loop;
    logic [1:0] control_loop_select;
  } vdsc_cfg_t;

  typedef struct packed {
    logic [15:0] prs;
    logic [15:0] pos;
  } vdsc_sp_t;

endpackage : vdsc_pkg

// File: verification/vdsc_host.sv
// Wishbone host model that writes and reads the state control registers
`timescale 1ns/1ps
`default_nettype none

module vdsc_host (
  // Clock
  input  wire logic        clk_i,
  // Wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);

  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  // One classic cycle, request held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= wd;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_adr_o <= ~adr;
    wb_dat_o <= ~wd;
  endtask : xfer

endmodule : vdsc_host

`default_nettype wire

// File: verification/vdsc_top_test.sv
// Self-checking bench for the valve device state control
`timescale 1ns/1ps
`default_nettype none
`include "vdsc_consts.svh"

module vdsc_top_test;

  logic                  clk_i;
  logic                  rst_i;
  logic                  cyc;
  logic                  stb;
  logic                  we;
  logic [7:0]            adr;
  logic [3:0]            sel;
  logic [31:0]           wdat;
  logic [31:0]           rdat;
  logic                  ack;
  logic                  hw_en;
  logic                  fault;
  vdsc_pkg::vdsc_sp_t    local_sp;
  vdsc_pkg::vdsc_state_t state;
  logic                  vfon;
  logic                  dron;
  logic                  posl;
  logic                  prsl;
  logic                  openl;
  logic                  rfz;
  logic                  prp;
  vdsc_pkg::vdsc_sp_t    demand;
  int                    failures = 0;
  int                    checks = 0;
  int                    cyc_cnt = 0;

  vdsc_host host_i (
    .clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat),
    .wb_ack_i(ack)
  );

  vdsc_top vdsc_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .hw_enable_i(hw_en),
    .ctrl_fault_i(fault), .local_sp_i(local_sp), .state_o(state),
    .valve_func_on_o(vfon), .driver_on_o(dron), .pos_loop_o(posl),
    .prs_loop_o(prsl), .open_loop_o(openl), .ramp_freeze_o(rfz),
    .prs_permit_o(prp), .demand_o(demand)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host_i.xfer(1'b1, a, d, r);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host_i.xfer(1'b0, a, 32'h0000_0000, d);
    #1;
  endtask : rd

  task automatic st(input logic [2:0] e);
    chk("state", {29'h0, state}, {29'h0, e});
  endtask : st

  task automatic en_set(input logic v);
    @(posedge clk_i);
    hw_en <= v;
    repeat (6) @(posedge clk_i);
    #1;
  endtask : en_set

  task automatic fault_pulse;
    @(posedge clk_i);
    fault <= 1'b1;
    @(posedge clk_i);
    fault <= 1'b0;
    #1;
  endtask : fault_pulse

  task automatic t_reset;
    logic [31:0] r;
    rd(`VDSC_ADR_STATUS, r);
    chk("status", r, 32'h0000_0000);
    chk("valve_func", {31'h0, vfon}, 32'h0000_0000);
    rd(`VDSC_ADR_CAPAB, r);
    chk("capab", r, 32'h0000_000F);
    rd(8'h40, r);
    chk("unmapped", r, 32'h0000_0000);
    rd(`VDSC_ADR_CMD_STD, r);
    chk("cmd_std", r, 32'h0000_0000);
    rd(`VDSC_ADR_CMD_VND, r);
    chk("cmd_vnd", r, 32'h0000_0003);
  endtask : t_reset

  task automatic t_states;
    logic [31:0] e;
    en_set(1'b1);
    wr(`VDSC_ADR_BUS_SP, 32'h1111_2222);
    wr(`VDSC_ADR_HOLD_SP, 32'h3333_4444);
    for (int i = 0; i < 4; i++) begin
      wr(`VDSC_ADR_CMD_STD, 32'(i));
      st(3'(i));
      chk("driver_on", {31'h0, dron}, 32'(i >= 2));
      chk("valve_func", {31'h0, vfon}, 32'(i != 0));
      e = (i == 2) ? 32'h3333_4444 : (i == 3) ? 32'h1111_2222 : 0;
      chk("demand", demand, e);
    end
    wr(`VDSC_ADR_CONFIG, 32'h0000_0008);
    chk("demand_local", demand, 32'h5555_6666);
    wr(`VDSC_ADR_CONFIG, 32'h0000_0000);
  endtask : t_states

  task automatic t_enable;
    en_set(1'b0);
    st(3'h1);
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0002);
    st(3'h1);
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0003);
    en_set(1'b1);
    st(3'h3);
  endtask : t_enable

  task automatic t_vendor;
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0001);
    st(3'h1);
    wr(`VDSC_ADR_CONFIG, 32'h0000_0010);
    st(3'h3);
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0000);
    st(3'h3);
    wr(`VDSC_ADR_CMD_VND, 32'h0000_0002);
    st(3'h2);
    wr(`VDSC_ADR_CONFIG, 32'h0000_0000);
    st(3'h0);
    wr(`VDSC_ADR_CMD_VND, 32'h0000_0001);
    st(3'h0);
  endtask : t_vendor

  task automatic t_fault;
    logic [31:0] r;
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0003);
    fault_pulse();
    st(3'h4);
    rd(`VDSC_ADR_STATUS, r);
    chk("status_fault", r, 32'h0000_00CC);
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0003);
    st(3'h4);
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0006);
    st(3'h2);
    fault_pulse();
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0005);
    st(3'h1);
    rd(`VDSC_ADR_CMD_STD, r);
    chk("cmd_std_clr", r, 32'h0000_0001);
  endtask : t_fault

  task automatic t_modes;
    logic [4:0] cfg [6] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h07};
    logic [3:0] exp [6] = '{4'h4, 4'h2, 4'hE, 4'h5, 4'h3, 4'h3};
    wr(`VDSC_ADR_CMD_STD, 32'h0000_001B);
    st(3'h3);
    chk("ramp_freeze", {31'h0, rfz}, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      wr(`VDSC_ADR_CONFIG, {27'h0, cfg[i]});
      chk("loops", {28'h0, prp, posl, prsl, openl}, {28'h0, exp[i]});
    end
    wr(`VDSC_ADR_CMD_STD, 32'h0000_0003);
    chk("ramp_freeze", {31'h0, rfz}, 32'h0000_0000);
    st(3'h3);
    wr(`VDSC_ADR_CONFIG, 32'h0000_0002);
    chk("no_permit", {28'h0, prp, posl, prsl, openl}, 32'h0000_0004);
  endtask : t_modes

  initial begin
    rst_i    = 1'b1;
    hw_en    = 1'b0;
    fault    = 1'b0;
    local_sp = 32'h5555_6666;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_states();
    t_enable();
    t_vendor();
    t_fault();
    t_modes();
    final_report();
  end

endmodule : vdsc_top_test

`default_nettype wire
